// >>> rtl/etxm_port.sv
// Multiplexed transmit backplane port: pin sampling, link demux and registers.
// Functional notes
// - bus one feeds links one to four, bus two feeds links five to eight.
// - signaling arrives in the timeslot of its payload and stays paired with it.
// - frame pulse sampled on the edge picked by the frame-edge select bit.
// - payload and signaling sampled on the edge picked by the data-edge select.
// - with unequal edge selects the frame pulse leads the first bit by one edge.
// - clock-rate select picks a bus clock at bit rate or twice bit rate.
// - at double rate, link one's bit-offset edge bit picks which of two edges samples data for all links.
// - at double rate the frame pulse is sampled on the first edge of a bit.
// - frame-pulse type picks basic frame or multiframe marking of link one.
// - frame-pulse polarity picks an active-high or active-low frame pulse.
// - flag set when pulse spacing is not a whole number of frames.
// - interrupt output goes low while the flag and its enable are both one.
// - bit and timeslot offsets apply at both clock rates in multiplexed mode; signaling follows payload.
// - timeslot offset spans 0 to 31 non-multiplexed, 0 to 127 multiplexed.
// - single rate: frame start lags pulse by N cycles plus 8 times M cycles.
// - double rate: frame start lags pulse by 2N cycles plus 16 times M cycles.
// - a global bus-select bit picks the main or the backup set of inputs.
`include "etxm_params.svh"

module etxm_port
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output wire logic                hreadyout,
    output wire logic [31:0]         hrdata,
    output wire logic                hresp,
    input  wire logic                mux_tx_bus_clock,
    input  wire logic                mux_tx_frame_pulse,
    input  wire logic [1:0]          mux_tx_data_set_a,
    input  wire logic [1:0]          mux_tx_signaling_a,
    input  wire logic [1:0]          mux_tx_data_set_b,
    input  wire logic [1:0]          mux_tx_signaling_b,
    output wire logic                int_n,
    output wire logic [1:0]          lane_valid,
    output etxm_pkg::etxm_lane_link_t lane_link,
    output etxm_pkg::etxm_lane_ts_t  lane_ts,
    output etxm_pkg::etxm_lane_frm_t lane_frame,
    output etxm_pkg::etxm_lane_byte_t lane_data,
    output etxm_pkg::etxm_lane_byte_t lane_sig
);
    import etxm_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    etxm_if        bus_if ();
    etxm_port_st_t st_q;
    etxm_port_st_t st_d;
    logic          mux_on;
    logic          clock_rate_sel;
    logic          fev;
    logic          dev;
    logic          fpl;
    logic          fp_hit;
    logic          fresh;
    logic          ph;
    logic          take;
    logic          first_now;
    etxm_pos_t     cur;
    etxm_pos_t     rel;
    logic [2:0]    lk;
    logic          ap;
    logic          in_map;
    logic [10:0]   idx;
    logic [2:0]    wl;
    logic [7:0]    ws;
    logic [7:0]    wv;

    // Frame start sits this many bus bits behind the pulse; a bit lasts one or two clocks.
    function automatic etxm_pos_t etxm_rel(etxm_pos_t pos, logic [7:0] tso, logic [7:0] bof);
        return 10'(pos - {tso[6:0], 3'b000} - {7'h00, bof[2:0]});
    endfunction

    function automatic logic [7:0] etxm_wmask(logic [7:0] sel, logic mux);
        case (sel)
            `ETXM_IDX_GLOBAL: return `ETXM_MSK_GLOBAL;
            `ETXM_IDX_OPTION: return `ETXM_MSK_OPTION;
            `ETXM_IDX_OPMODE: return `ETXM_MSK_OPMODE;
            `ETXM_IDX_TSOFF:  return mux ? `ETXM_MSK_TS_MUX : `ETXM_MSK_TS_NMUX;
            `ETXM_IDX_BITOFF: return `ETXM_MSK_BITOFF;
            `ETXM_IDX_IRQCTL: return `ETXM_MSK_IRQCTL;
            `ETXM_IDX_PLCEN:  return `ETXM_MSK_PLCEN;
            default:          return 8'h00;
        endcase
    endfunction

    // ****************************************************************
    // Pin sampling and frame counting
    // ****************************************************************
    etxm_edge_sync u_sync
    (
        .clk   (clk),
        .reset (reset),
        .pins  ({mux_tx_signaling_b, mux_tx_data_set_b, mux_tx_signaling_a,
                 mux_tx_data_set_a, mux_tx_frame_pulse, mux_tx_bus_clock}),
        .sy    (bus_if.snc)
    );

    etxm_frame_cnt u_cnt
    (
        .clk   (clk),
        .reset (reset),
        .cn    (bus_if.cnt)
    );

    assign bus_if.bit_tick = take;
    assign bus_if.start    = take & first_now;
    assign bus_if.frame_pulse_type    = st_q.opt[0][`ETXM_OP_FRAME_PULSE_TYPE];

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        st_d   = st_q;
        rel    = '0;
        lk     = '0;
        wl     = '0;
        ws     = '0;
        wv     = '0;
        mux_on = st_q.gbl[`ETXM_GB_MUX];

        // The bus is shared by all links, so link one's copy of each select governs it.
        clock_rate_sel = st_q.opt[0][`ETXM_OP_CMS];
        fev = st_q.opt[0][`ETXM_OP_FE] ? bus_if.clk_fall : bus_if.clk_rise;
        dev = (st_q.opt[0][`ETXM_OP_DE] ? bus_if.clk_fall : bus_if.clk_rise) & mux_on;
        fpl = bus_if.fp ^ st_q.opt[0][`ETXM_OP_FRAME_PULSE_POLARITY];

        // Until the first pulse is found the edge phase is unknown, so every edge may catch it.
        fp_hit    = fev & fpl & mux_on & (~clock_rate_sel | ~st_q.fph | ~st_q.lock);
        fresh     = fp_hit | st_q.fp_pend;
        ph        = fresh ? 1'b0 : st_q.dph;
        take      = dev & (~clock_rate_sel | (ph == st_q.bof[0][`ETXM_BO_EDGE]));
        first_now = fresh | st_q.first;
        cur       = first_now ? '0 : 10'(bus_if.pos + 10'h001);

        if (fev & mux_on)
        begin
            st_d.fph  = fp_hit ? 1'b1 : ~st_q.fph;
            st_d.lock = st_q.lock | fp_hit;
        end
        if (dev)
        begin
            st_d.fp_pend = 1'b0;
            st_d.dph     = ~ph;
            st_d.first   = first_now & ~take;
        end
        else if (fp_hit)
        begin
            // The pulse was caught on the other edge; the next data edge holds bit zero.
            st_d.fp_pend = 1'b1;
        end

        // ************************************************************
        // Demultiplexing of the two buses
        // ************************************************************
        st_d.vld = '0;
        for (int b = 0; b < 2; b++)
        begin
            if (take)
            begin
                st_d.shd[b] = {st_q.shd[b][6:0],
                               st_q.gbl[`ETXM_GB_SETB] ? bus_if.dat_b[b] : bus_if.dat_a[b]};
                st_d.shs[b] = {st_q.shs[b][6:0],
                               st_q.gbl[`ETXM_GB_SETB] ? bus_if.sig_b[b] : bus_if.sig_a[b]};
                // Equal offsets collide; the lowest link wins and the others lose the byte.
                for (int k = 3; k >= 0; k--)
                begin
                    lk  = 3'(b * 4 + k);
                    rel = etxm_rel(cur, st_q.tso[lk], st_q.bof[lk]);
                    if (rel[4:0] == `ETXM_BYTE_END)
                    begin
                        st_d.vld[b] = 1'b1;
                        st_d.lnk[b] = lk;
                        st_d.ts[b]  = rel[9:5];
                        st_d.frm[b] = bus_if.frm;
                        st_d.dat[b] = st_d.shd[b];
                        st_d.sig[b] = st_d.shs[b];
                    end
                end
            end
        end

        // ************************************************************
        // Register access
        // ************************************************************
        ap     = hsel & hready & htrans[1];
        in_map = (haddr[31:13] == 19'h00000);
        idx    = haddr[12:2];
        st_d.wr_pend = ap & hwrite & in_map;
        if (ap & hwrite)
            st_d.wr_idx = idx;

        if (ap & ~hwrite)
        begin
            st_d.rdata = '0;
            lk         = idx[10:8];
            if (in_map)
            begin
                case (idx[7:0])
                    `ETXM_IDX_GLOBAL: st_d.rdata = (lk == 3'h0) ? st_q.gbl : 8'h00;
                    `ETXM_IDX_OPTION: st_d.rdata = st_q.opt[lk];
                    `ETXM_IDX_OPMODE: st_d.rdata = st_q.mode[lk];
                    `ETXM_IDX_TSOFF:  st_d.rdata = st_q.tso[lk];
                    `ETXM_IDX_BITOFF: st_d.rdata = st_q.bof[lk];
                    `ETXM_IDX_IRQCTL: st_d.rdata = st_q.ien[lk];
                    `ETXM_IDX_PLCEN:  st_d.rdata = st_q.plc[lk];
                    `ETXM_IDX_CHANGE:
                    begin
                        // Reading the flag clears it.
                        st_d.rdata    = {7'h00, st_q.chg[lk]};
                        st_d.chg[lk]  = 1'b0;
                    end
                    default:          st_d.rdata = 8'h00;
                endcase
            end
        end

        if (st_q.wr_pend)
        begin
            wl = st_q.wr_idx[10:8];
            ws = st_q.wr_idx[7:0];
            wv = hwdata[7:0] & etxm_wmask(ws, mux_on);
            case (ws)
                `ETXM_IDX_GLOBAL:
                begin
                    if (wl == 3'h0)
                        st_d.gbl = wv;
                end
                `ETXM_IDX_OPTION: st_d.opt[wl]  = wv;
                `ETXM_IDX_OPMODE: st_d.mode[wl] = wv;
                `ETXM_IDX_TSOFF:  st_d.tso[wl]  = wv;
                `ETXM_IDX_BITOFF: st_d.bof[wl]  = wv;
                `ETXM_IDX_IRQCTL: st_d.ien[wl]  = wv;
                `ETXM_IDX_PLCEN:  st_d.plc[wl]  = wv;
                default:          st_d.gbl      = st_q.gbl;
            endcase
        end

        // A misplaced pulse shows in every link; it wins over a clearing read.
        if (bus_if.chg)
            st_d.chg = 8'hff;

        st_d.int_act = 1'b0;
        for (int l = 0; l < 8; l++)
        begin
            if (st_d.chg[l] & st_d.ien[l][0])
                st_d.int_act = 1'b1;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = {24'h000000, st_q.rdata};
    assign int_n      = ~st_q.int_act;
    assign lane_valid = st_q.vld;
    assign lane_link  = st_q.lnk;
    assign lane_ts    = st_q.ts;
    assign lane_frame = st_q.frm;
    assign lane_data  = st_q.dat;
    assign lane_sig   = st_q.sig;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_lead;
        fp_hit && !dev;
    endsequence
    sequence s_first_bit;
        take && first_now;
    endsequence

    chk_flag_set: assert property (bus_if.chg |=> &st_q.chg)
        else $error("change flag not set in all links");
    chk_irq_out: assert property (st_q.chg[0] && st_q.ien[0][0] |-> !int_n)
        else $error("interrupt not asserted for an enabled flag");
    chk_bus_one: assert property (lane_valid[0] |-> !lane_link[0][2])
        else $error("bus one delivered to a high link");
    chk_bus_two: assert property (lane_valid[1] |-> lane_link[1][2])
        else $error("bus two delivered to a low link");
    chk_pulse_lead: assert property (s_lead |=> st_q.fp_pend)
        else $error("leading pulse not held for the data edge");
    chk_frame_zero: assert property (s_first_bit |=> bus_if.pos == 10'h000)
        else $error("first bit after pulse not at position zero");
    chk_single_rate: assert property (!clock_rate_sel && dev |-> take)
        else $error("single rate data edge not taken");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
endmodule

// >>> common/etxm_params.svh
// Register indices, field positions, write masks and frame timing of the port.
`ifndef ETXM_PARAMS_SVH
`define ETXM_PARAMS_SVH
`define ETXM_IDX_GLOBAL  8'h10
`define ETXM_IDX_OPTION  8'h42
`define ETXM_IDX_OPMODE  8'h43
`define ETXM_IDX_TSOFF   8'h44
`define ETXM_IDX_BITOFF  8'h45
`define ETXM_IDX_CHANGE  8'h4b
`define ETXM_IDX_IRQCTL  8'h4c
`define ETXM_IDX_PLCEN   8'hcc
`define ETXM_MSK_GLOBAL  8'h07
`define ETXM_MSK_OPTION  8'h1f
`define ETXM_MSK_OPMODE  8'h03
`define ETXM_MSK_TS_MUX  8'h7f
`define ETXM_MSK_TS_NMUX 8'h1f
`define ETXM_MSK_BITOFF  8'h0f
`define ETXM_MSK_IRQCTL  8'h01
`define ETXM_MSK_PLCEN   8'hff
`define ETXM_RST_REG     8'h00
`define ETXM_GB_MUX      0
`define ETXM_GB_SETB     1
`define ETXM_OP_FE       0
`define ETXM_OP_DE       1
`define ETXM_OP_FRAME_PULSE_TYPE    2
`define ETXM_OP_FRAME_PULSE_POLARITY    3
`define ETXM_OP_CMS      4
`define ETXM_BO_EDGE     3
`define ETXM_FRAME_US    125
`define ETXM_MUX_KBPS    8192
`define ETXM_FRAME_BITS  (`ETXM_FRAME_US * `ETXM_MUX_KBPS / 1000)
`define ETXM_LAST_BIT    10'(`ETXM_FRAME_BITS - 1)
`define ETXM_BYTE_END    5'h07
`endif

// >>> common/etxm_pkg.sv
// Shared types of the multiplexed transmit backplane port.
package etxm_pkg;
    typedef logic [9:0]      etxm_pos_t;
    typedef logic [1:0][2:0] etxm_lane_link_t;
    typedef logic [1:0][4:0] etxm_lane_ts_t;
    typedef logic [1:0][3:0] etxm_lane_frm_t;
    typedef logic [1:0][7:0] etxm_lane_byte_t;
    typedef struct packed {
        logic [9:0] s1;
        logic [9:0] s2;
        logic       ck3;
    } etxm_sync_st_t;
    typedef struct packed {
        etxm_pos_t  pos;
        logic [3:0] frm;
        logic       seen;
        logic       chg;
    } etxm_cnt_st_t;
    typedef struct packed {
        logic [7:0]      gbl;
        logic [7:0][7:0] opt;
        logic [7:0][7:0] mode;
        logic [7:0][7:0] tso;
        logic [7:0][7:0] bof;
        logic [7:0][7:0] ien;
        logic [7:0][7:0] plc;
        logic [7:0]      chg;
        logic            int_act;
        logic            fp_pend;
        logic            fph;
        logic            lock;
        logic            dph;
        logic            first;
        etxm_lane_byte_t shd;
        etxm_lane_byte_t shs;
        logic            wr_pend;
        logic [10:0]     wr_idx;
        logic [7:0]      rdata;
        logic [1:0]      vld;
        etxm_lane_link_t lnk;
        etxm_lane_ts_t   ts;
        etxm_lane_frm_t  frm;
        etxm_lane_byte_t dat;
        etxm_lane_byte_t sig;
    } etxm_port_st_t;
endpackage

// >>> common/etxm_if.sv
// Internal signals between the pin sampler, the frame counter and the port.
interface etxm_if;
    logic                clk_rise;
    logic                clk_fall;
    logic                fp;
    logic [1:0]          dat_a;
    logic [1:0]          sig_a;
    logic [1:0]          dat_b;
    logic [1:0]          sig_b;
    logic                bit_tick;
    logic                start;
    logic                frame_pulse_type;
    logic                chg;
    etxm_pkg::etxm_pos_t pos;
    logic [3:0]          frm;
    modport snc (output clk_rise, clk_fall, fp, dat_a, sig_a, dat_b, sig_b);
    modport cnt (input bit_tick, start, frame_pulse_type, output pos, frm, chg);
endinterface

// >>> rtl/etxm_edge_sync.sv
// Two-stage synchroniser for the bus pins and edge finder for the bus clock.
module etxm_edge_sync
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [9:0] pins,
    etxm_if.snc             sy
);
    import etxm_pkg::*;
    etxm_sync_st_t st_q;
    etxm_sync_st_t st_d;

    always_comb
    begin
        st_d     = st_q;
        st_d.s1  = pins;
        st_d.s2  = st_q.s1;
        st_d.ck3 = st_q.s2[0];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // Data pins go through the same two stages, so they line up with the clock edges.
    assign sy.clk_rise = st_q.s2[0] & ~st_q.ck3;
    assign sy.clk_fall = ~st_q.s2[0] & st_q.ck3;
    assign sy.fp       = st_q.s2[1];
    assign sy.dat_a    = st_q.s2[3:2];
    assign sy.sig_a    = st_q.s2[5:4];
    assign sy.dat_b    = st_q.s2[7:6];
    assign sy.sig_b    = st_q.s2[9:8];

    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_edge_excl: assert property (!(sy.clk_rise && sy.clk_fall))
        else $error("rise and fall seen together");
    chk_rise_lat: assert property ($rose(pins[0]) ##1 pins[0] |=> sy.clk_rise)
        else $error("clock rise not found two cycles later");
endmodule

// >>> rtl/etxm_frame_cnt.sv
// Bit position counter of the bus frame and frame pulse spacing monitor.
`include "etxm_params.svh"

module etxm_frame_cnt
(
    input  wire logic clk,
    input  wire logic reset,
    etxm_if.cnt       cn
);
    import etxm_pkg::*;
    etxm_cnt_st_t st_q;
    etxm_cnt_st_t st_d;
    logic         wrap;

    always_comb
    begin
        st_d     = st_q;
        st_d.chg = 1'b0;
        wrap     = (st_q.pos == `ETXM_LAST_BIT);
        if (cn.bit_tick)
        begin
            st_d.pos = cn.start ? '0 : 10'(st_q.pos + 10'h001);
            if (cn.start)
            begin
                // After the first pulse, a pulse is legal only right after the last bit of a frame.
                st_d.chg  = st_q.seen & ~wrap;
                st_d.seen = 1'b1;
            end
            if (cn.start & cn.frame_pulse_type)
                st_d.frm = '0;
            else if (cn.start | wrap)
                st_d.frm = 4'(st_q.frm + 4'h1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign cn.pos = st_q.pos;
    assign cn.frm = st_q.frm;
    assign cn.chg = st_q.chg;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_pos_step: assert property (cn.bit_tick && !cn.start |=> cn.pos == 10'($past(cn.pos) + 10'h001))
        else $error("bit position did not advance by one");
    chk_chg_mis: assert property (cn.bit_tick && cn.start && st_q.seen && !wrap |=> cn.chg)
        else $error("misplaced frame pulse not flagged");
    chk_frm_mf: assert property (cn.bit_tick && cn.start && cn.frame_pulse_type |=> cn.frm == 4'h0)
        else $error("multiframe pulse did not restart frame count");
endmodule

// >>> tb/etxm_bus_model.sv
// Behavioural system-side master of the multiplexed transmit bus.
module etxm_bus_model
(
    input  wire logic       run,
    input  wire logic [9:0] last_pos,
    input  wire logic       fp_inv,
    output logic            mux_tx_bus_clock,
    output logic            mux_tx_frame_pulse,
    output logic [1:0]      mux_tx_data_set_a,
    output logic [1:0]      mux_tx_signaling_a,
    output logic [1:0]      mux_tx_data_set_b,
    output logic [1:0]      mux_tx_signaling_b
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] pos;
    logic [7:0] v;
    // Kind 0 and 1 are payload of bus one and two, kind 2 and 3 their signaling.
    function automatic logic [7:0] pat(input logic [1:0] kind, input logic [6:0] ts);
        return {1'b0, ts} * 8'h1d + {kind, 6'h00} + 8'h33;
    endfunction
    // ********************************************************
    // Bus clock, frame pulse and interleaved bytes
    // ********************************************************
    initial
    begin
        mux_tx_bus_clock = 1'b0;
        mux_tx_frame_pulse = 1'b0;
        pos = 10'h000;
        {mux_tx_data_set_a, mux_tx_signaling_a, mux_tx_data_set_b, mux_tx_signaling_b} = 8'h5a;
        // Keep bus edges off the system clock edges, so no pin changes in a sampling step.
        #0.3;
        forever
        begin
            #62.5;
            mux_tx_bus_clock = 1'b0;
            if (run)
            begin
                mux_tx_frame_pulse = (pos == 10'h000) ^ fp_inv;
                for (int k = 0; k < 4; k++)
                begin
                    v = pat(2'(k), pos[9:3]);
                    if (k < 2)
                        mux_tx_data_set_a[k] = v[~pos[2:0]];
                    else
                        mux_tx_signaling_a[k-2] = v[~pos[2:0]];
                end
                mux_tx_data_set_b = ~mux_tx_data_set_a;
                mux_tx_signaling_b = ~mux_tx_signaling_a;
                pos = (pos == last_pos) ? 10'h000 : pos + 10'h001;
            end
            else
            begin
                // Released lines toggle so that a stale level never passes for data.
                mux_tx_frame_pulse = fp_inv;
                mux_tx_data_set_a = ~mux_tx_data_set_a;
                mux_tx_signaling_a = ~mux_tx_signaling_a;
                mux_tx_data_set_b = ~mux_tx_data_set_b;
                mux_tx_signaling_b = ~mux_tx_signaling_b;
                pos = 10'h000;
            end
            #62.5;
            mux_tx_bus_clock = run;
        end
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench of the multiplexed transmit backplane port.
`include "etxm_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import etxm_pkg::*;
    typedef struct packed {logic [2:0] l; logic [7:0] i; logic [7:0] w; logic [7:0] r;} etxm_row_t;
    logic            clk, reset, hsel, hwrite, run, mon_on, sel_b, fp_inv, f_ok;
    logic [3:0]      f_prev;
    logic [31:0]     haddr, hwdata, hrdata, rd;
    logic [1:0]      htrans, lane_valid;
    logic [9:0]      last_pos;
    logic            hreadyout, hresp, int_n, mux_tx_bus_clock, mux_tx_frame_pulse;
    logic [1:0]      mux_tx_data_set_a, mux_tx_signaling_a, mux_tx_data_set_b, mux_tx_signaling_b;
    etxm_lane_link_t lane_link;
    etxm_lane_ts_t   lane_ts;
    etxm_lane_frm_t  lane_frame;
    etxm_lane_byte_t lane_data, lane_sig;
    int              n_errors, n_compared, nv [2];
    etxm_row_t       rows [10] = '{
        '{3'd0, `ETXM_IDX_OPTION, 8'hff, 8'h1f},
        '{3'd3, `ETXM_IDX_BITOFF, 8'hff, 8'h0f},
        '{3'd1, `ETXM_IDX_TSOFF, 8'hff, 8'h1f},
        '{3'd5, `ETXM_IDX_IRQCTL, 8'hff, 8'h01},
        '{3'd7, `ETXM_IDX_PLCEN, 8'ha5, 8'ha5},
        '{3'd2, `ETXM_IDX_OPMODE, 8'hff, 8'h03},
        '{3'd4, `ETXM_IDX_CHANGE, 8'hff, 8'h00},
        '{3'd0, 8'h50, 8'hff, 8'h00},
        '{3'd0, `ETXM_IDX_GLOBAL, 8'hff, 8'h07},
        '{3'd1, `ETXM_IDX_TSOFF, 8'hff, 8'h7f}};
    etxm_port dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .mux_tx_bus_clock, .mux_tx_frame_pulse, .mux_tx_data_set_a,
        .mux_tx_signaling_a, .mux_tx_data_set_b, .mux_tx_signaling_b, .int_n, .lane_valid, .lane_link,
        .lane_ts, .lane_frame, .lane_data, .lane_sig);
    etxm_bus_model bm (.run, .last_pos, .fp_inv, .mux_tx_bus_clock, .mux_tx_frame_pulse, .mux_tx_data_set_a,
        .mux_tx_signaling_a, .mux_tx_data_set_b, .mux_tx_signaling_b);
    // ********************************************************
    // Clock, bus tasks and comparison
    // ********************************************************
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] ra(input int link, input logic [7:0] idx);
        return 32'((link * 256 + idx) * 4);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [7:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        for (int b = 0; b < 2; b++)
        begin
            logic [6:0] t;
            t = 7'(4 * lane_ts[b] + lane_link[b][1:0]);
            if (mon_on && lane_valid[b] === 1'b1)
            begin
                nv[b]++;
                chk(32'(lane_link[b][2]), 32'(b));
                chk(32'(lane_data[b]), 32'(bm.pat(2'(b), t) ^ {8{sel_b}}));
                chk(32'(lane_sig[b]), 32'(bm.pat(2'(b + 2), t) ^ {8{sel_b}}));
            end
        end
        if (mon_on && lane_valid[0] === 1'b1 && lane_link[0] == 3'h0 && lane_ts[0] == 5'h00)
        begin
            if (f_ok)
                chk(32'(lane_frame[0]), 32'(4'(f_prev + 4'h1)));
            f_prev = lane_frame[0];
        end
        f_ok = mon_on & (f_ok | (lane_valid[0] === 1'b1 && lane_link[0] == 3'h0 && lane_ts[0] == 5'h00));
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        test_done;
    end
    // ********************************************************
    // Scenarios
    // ********************************************************
    initial
    begin
        {reset, hsel, haddr, htrans, hwrite, hwdata, run, mon_on, sel_b} = {1'b1, 72'h0};
        {last_pos, n_errors, n_compared, nv[0], nv[1]} = {10'h3ff, 128'h0};
        fp_inv = 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(32'({int_n, lane_valid}), 32'h4);
        foreach (rows[i])
        begin
            ahb(1'b0, ra(rows[i].l, rows[i].i), 8'h00);
            chk(rd, 32'h0);
        end
        foreach (rows[i])
        begin
            ahb(1'b1, ra(rows[i].l, rows[i].i), rows[i].w);
            ahb(1'b0, ra(rows[i].l, rows[i].i), 8'h00);
            chk(rd, 32'(rows[i].r));
        end
        for (int l = 0; l < 8; l++)
        begin
            ahb(1'b1, ra(l, `ETXM_IDX_OPTION), 8'h08);
            ahb(1'b1, ra(l, `ETXM_IDX_BITOFF), 8'h00);
            ahb(1'b1, ra(l, `ETXM_IDX_TSOFF), 8'(l % 4));
            ahb(1'b1, ra(l, `ETXM_IDX_IRQCTL), 8'h01);
        end
        ahb(1'b1, ra(0, `ETXM_IDX_GLOBAL), 8'h01);
        run <= 1'b1;
        mon_on <= 1'b1;
        repeat (17000) @(posedge clk);
        nv = '{0, 0};
        repeat (16000) @(posedge clk);
        chk(32'(nv[0] inside {[127:129]}), 32'h1);
        chk(32'(nv[1] inside {[127:129]}), 32'h1);
        ahb(1'b0, ra(0, `ETXM_IDX_CHANGE), 8'h00);
        chk({rd[31:1], int_n}, 32'h1);
        mon_on <= 1'b0;
        last_pos <= 10'd511;
        repeat (20000) @(posedge clk);
        last_pos <= 10'h3ff;
        repeat (10000) @(posedge clk);
        chk(32'(int_n), 32'h0);
        for (int e = 0; e < 2; e++)
        begin
            for (int l = 0; l < 8; l++)
                ahb(1'b1, ra(l, `ETXM_IDX_IRQCTL), 8'(e));
            repeat (2) @(posedge clk);
            chk(32'(int_n), 32'(1 - e));
        end
        for (int l = 0; l < 9; l++)
        begin
            ahb(1'b0, ra(l % 8, `ETXM_IDX_CHANGE), 8'h00);
            chk(rd, 32'(l < 8));
        end
        repeat (2) @(posedge clk);
        chk(32'(int_n), 32'h1);
        ahb(1'b1, ra(0, `ETXM_IDX_GLOBAL), 8'h03);
        repeat (300) @(posedge clk);
        {sel_b, mon_on} <= 2'b11;
        nv = '{0, 0};
        repeat (8000) @(posedge clk);
        chk(32'(nv[0] > 0 && nv[1] > 0), 32'h1);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        mon_on <= 1'b0;
        ahb(1'b0, ra(0, `ETXM_IDX_GLOBAL), 8'h00);
        chk(rd, 32'h0);
        test_done;
    end
endmodule
